/* src/frt_cfg.svh */
// Register map, field positions, reset values and timing counts
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH

// Word offsets (byte addresses) on the Wishbone slave
`define FRT_ADDR_W 4
`define FRT_OFS_COUNT 4'h0
`define FRT_OFS_CAPTURE 4'h4
`define FRT_OFS_MODE 4'h8
`define FRT_OFS_TONE 4'hc

// Mode control fields
`define FRT_MODE_TOE 0
`define FRT_MODE_CLK_LO 1
`define FRT_MODE_CLK_HI 2
`define FRT_MODE_TOC 3
`define FRT_MODE_CPT_LO 4
`define FRT_MODE_CPT_HI 5
`define FRT_MODE_MASK 6
`define FRT_MODE_FLAG 7
`define FRT_MODE_MATCH_LO 16
`define FRT_MODE_MATCH_HI 31

// Tone control fields
`define FRT_TONE_EN 0
`define FRT_TONE_SEL_LO 1
`define FRT_TONE_SEL_HI 3

// Reset values
`define FRT_COUNT_RST 16'h0000
`define FRT_MODE_RST 8'h40
`define FRT_MATCH_RST 16'hffff

// Count clock prescale exponents for select codes 00, 01, 10
`define FRT_PRE_EXP0 5'h02
`define FRT_PRE_EXP1 5'h06
`define FRT_PRE_EXP2 5'h04
`define FRT_PRE_W 6

// Capture must land within this many clocks of the detected edge
`define FRT_CAPTURE_LAT 2
`endif

/* src/frt_pkg.sv */
// Types shared by the free-running timer block
package frt_pkg;
   // Capture edge selection
   typedef enum logic [1:0] {
      frt_cap_off,
      frt_cap_rise,
      frt_cap_fall,
      frt_cap_both
   } frt_edge_t;
   // Counter read buffer state
   typedef enum logic {
      frt_buf_follow,
      frt_buf_frozen
   } frt_buf_t;
endpackage

/* src/frt_edge_det.sv */
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ns
module frt_edge_det (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire frt_pkg::frt_edge_t sel_i,
   output logic hit_o
);
   logic sync_a; // First synchroniser stage
   logic sync_b; // Second stage, safe to use
   logic sync_c; // Delayed copy for edges

   // Two-flop synchroniser and history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Select decodes edge
   // Qualify the edge by the selection, one pulse per edge
   always_comb begin
      case (sel_i)
         frt_pkg::frt_cap_rise: hit_o = sync_b & ~sync_c;
         frt_pkg::frt_cap_fall: hit_o = ~sync_b & sync_c;
         frt_pkg::frt_cap_both: hit_o = sync_b ^ sync_c;
         default: hit_o = 1'b0;
      endcase
   end
endmodule // frt_edge_det

/* src/frt_timer.sv */
// Free-running timer with capture, read buffer, match and tone output
`timescale 1ns/1ns
`include "frt_cfg.svh"

// Summary of operation
// - Selected pin edge copies count to capture
// - Capture within two clocks, held otherwise
// - Edge select: off, rise, fall, both
// - Low-byte read freezes counter read buffer
// - High-byte read end releases the buffer
// - Reset clears counter, counting resumes alone
// - Lone low read leaves buffer frozen
// - Counter runs on; post-stop value undefined
// - Tone divides count clock by select code
// - Unmasked rewrite may raise match request
// - Rewrite timing may double the interval
// - Match pulse lasts half count period
// - Match raises request, counter keeps running
module frt_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`FRT_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic capture_trigger_pin_i,
   output logic match_irq_o,
   output logic toggle_out_o,
   output logic tone_out_o
);
   logic [15:0] free_run_count; // Counter
   logic [15:0] read_buf; // Counter read buffer
   frt_pkg::frt_buf_t buf_state; // Follow or frozen
   logic [15:0] capture_hold_reg; // Captured count
   logic [15:0] match_value_reg; // Compare value
   logic [7:0] timer_mode_ctrl; // Mode control
   logic [3:0] tone_ctrl_reg; // Tone control
   logic [`FRT_PRE_W-1:0] prescale; // Count clock prescaler
   logic [5:0] pre_exp; // Selected prescale exponent
   logic count_tick; // One cycle per count clock
   logic [13:0] tone_div; // Tone divider
   logic [3:0] tone_bit; // Divider bit for tone
   logic cap_hit; // Qualified capture edge
   logic match_hit; // Compare equality at tick
   logic [`FRT_PRE_W-1:0] half_cnt; // Match pulse length count
   logic req; // Wishbone request pending
   logic lo_read; // Low-byte read strobe
   logic hi_read; // High-byte read strobe
   logic hi_read_d; // Delayed high-byte strobe
   logic [31:0] next_rdata; // Read mux
   logic clk_sel_ok; // Count clock selection valid
   logic mask_bit; // Match mask
   logic [1:0] clk_sel; // Count clock select
   logic toc_d; // Toggle-on-match enable, one clock late

   assign clk_sel = {timer_mode_ctrl[`FRT_MODE_CLK_HI],
                     timer_mode_ctrl[`FRT_MODE_CLK_LO]};
   assign mask_bit = timer_mode_ctrl[`FRT_MODE_MASK];
   assign clk_sel_ok = (clk_sel != 2'h3);

   // Count clock exponent per select code
   always_comb begin
      case (clk_sel)
         // Exponent is the log of the count clock divider
         2'h0: pre_exp = {1'b0, `FRT_PRE_EXP0};
         2'h1: pre_exp = {1'b0, `FRT_PRE_EXP1};
         2'h2: pre_exp = {1'b0, `FRT_PRE_EXP2};
         // Select 11 stops the count clock
         default: pre_exp = 6'h00;
      endcase
   end

   // Prescaler; tick when the low exponent bits roll over
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescale <= '0;
      end else begin
         // Wraps every 64 clocks, never loaded
         prescale <= prescale + 6'h01;
      end
   end

   // Tick when all bits below the exponent are ones
   always_comb begin
      count_tick = clk_sel_ok;
      for (int i = 0; i < `FRT_PRE_W; i++) begin
         // A low bit still zero means no tick yet
         if (i < pre_exp && !prescale[i]) begin
            count_tick = 1'b0;
         end
      end
   end

   // Counting gated only by the count tick; select 11 stops it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         free_run_count <= `FRT_COUNT_RST;
      end else if (count_tick) begin
         // Wraps from ffff to 0000, never cleared
         free_run_count <= free_run_count + 16'h0001;
      end
   end

   // Equality at a count tick, counter not cleared
   assign match_hit = count_tick && (free_run_count == match_value_reg);

   // Match pulse held for half a count period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_cnt <= '0;
      end else if (match_hit) begin
         // Load half the count period in clocks
         half_cnt <= 6'(1 << (pre_exp - 6'h01));
      end else if (half_cnt != '0) begin
         // Count the window down to idle
         half_cnt <= half_cnt - 6'h01;
      end
   end

   // Unmasked flag drives request, even right after rewrite
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_irq_o <= 1'b0;
      end else begin
         // Level follows the flag, gated by the mask
         match_irq_o <= timer_mode_ctrl[`FRT_MODE_FLAG] & ~mask_bit;
      end
   end

   // Toggle-on-match enable delayed, to spot it being switched on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         toc_d <= 1'b0;
      end else begin
         toc_d <= timer_mode_ctrl[`FRT_MODE_TOC];
      end
   end

   // Toggle inverts on match or on enable inside pulse window
   // Enabling inside the window inverts once: a hazard for software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         toggle_out_o <= 1'b0;
      end else if (!timer_mode_ctrl[`FRT_MODE_TOE]) begin
         // Output disabled starts low again
         toggle_out_o <= 1'b0;
      end else if (timer_mode_ctrl[`FRT_MODE_TOC] &&
                   (match_hit || (half_cnt != '0 && !toc_d))) begin
         // Invert on match, or on a fresh enable in the window
         toggle_out_o <= ~toggle_out_o;
      end
   end

   frt_edge_det u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(capture_trigger_pin_i),
      .sel_i(frt_pkg::frt_edge_t'(timer_mode_ctrl[`FRT_MODE_CPT_HI:
                                                  `FRT_MODE_CPT_LO])),
      .hit_o(cap_hit)
   );

   // Taken next clock, held until next edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_hold_reg <= 16'h0000;
      end else if (cap_hit) begin
         // Latch the count, kept until the next edge
         capture_hold_reg <= free_run_count;
      end
   end

   // Wishbone request and byte strobes for the counter word
   // Ack is registered: answered one clock after the request
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign lo_read = req & ~wb_we_i & (wb_adr_i == `FRT_OFS_COUNT)
                    & wb_sel_i[0];
   assign hi_read = req & ~wb_we_i & (wb_adr_i == `FRT_OFS_COUNT)
                    & wb_sel_i[1];

   // High-byte strobe end marker
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_read_d <= 1'b0;
      end else begin
         // One clock late, marks where the strobe ends
         hi_read_d <= hi_read;
      end
   end

   // Freeze on low-byte read, follow otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_state <= frt_pkg::frt_buf_follow;
         read_buf <= `FRT_COUNT_RST;
      end else begin
         case (buf_state)
            frt_pkg::frt_buf_follow: begin
               // Track the live count until a low read
               read_buf <= free_run_count;
               if (lo_read) begin
                  buf_state <= frt_pkg::frt_buf_frozen;
               end
            end
            frt_pkg::frt_buf_frozen: begin
               // Hold until the high-byte strobe has ended
               if (hi_read_d && !hi_read) begin
                  buf_state <= frt_pkg::frt_buf_follow;
                  read_buf <= free_run_count;
               end
            end
            default: buf_state <= frt_pkg::frt_buf_follow;
         endcase
      end
   end

   // Read mux; counter low byte comes from the live value being frozen
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `FRT_OFS_COUNT: begin
            // A lone high-byte read gets the live count
            next_rdata[15:0] = (buf_state == frt_pkg::frt_buf_frozen)
                               ? read_buf : free_run_count;
         end
         `FRT_OFS_CAPTURE: next_rdata[15:0] = capture_hold_reg;
         `FRT_OFS_MODE: begin
            next_rdata[7:0] = timer_mode_ctrl;
            // Compare value shares the mode word
            next_rdata[31:16] = match_value_reg;
         end
         `FRT_OFS_TONE: next_rdata[3:0] = tone_ctrl_reg;
         // Holes read as zero
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Wishbone ack one cycle after request, read data registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         // Req is gated by ack, so ack lasts one clock
         wb_ack_o <= req;
         if (req) begin
            // Data stands until the next access
            wb_dat_o <= next_rdata;
         end
      end
   end

   // Mode register writes; flag set by match wins over clear
   // Compare value takes effect on next tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_mode_ctrl <= `FRT_MODE_RST;
         match_value_reg <= `FRT_MATCH_RST;
      end else begin
         if (req && wb_we_i && wb_adr_i == `FRT_OFS_MODE) begin
            if (wb_sel_i[0]) begin
               // Plain write, also clears a set flag
               timer_mode_ctrl <= wb_dat_i[7:0];
            end
            if (wb_sel_i[2]) begin
               // Either compare byte may land alone
               match_value_reg[7:0] <= wb_dat_i[23:16];
            end
            if (wb_sel_i[3]) begin
               match_value_reg[15:8] <= wb_dat_i[31:24];
            end
         end
         if (match_hit) begin
            timer_mode_ctrl[`FRT_MODE_FLAG] <= 1'b1;
         end
      end
   end

   // Tone control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_ctrl_reg <= 4'h0;
      end else if (req && wb_we_i && wb_adr_i == `FRT_OFS_TONE &&
                   wb_sel_i[0]) begin
         // Bits above the select are not stored
         tone_ctrl_reg <= wb_dat_i[3:0];
      end
   end

   // Tone divider runs on count clock ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_div <= 14'h0000;
      end else if (count_tick) begin
         // Phase is never reset by tone writes
         tone_div <= tone_div + 14'h0001;
      end
   end

   // Divider bit per select: 2^4,5,8..13 means bit n-1
   always_comb begin
      case (tone_ctrl_reg[`FRT_TONE_SEL_HI:`FRT_TONE_SEL_LO])
         // Half of 2^n ticks is bit n-1 of the divider
         3'h0: tone_bit = 4'h3;
         3'h1: tone_bit = 4'h4;
         3'h2: tone_bit = 4'h7;
         3'h3: tone_bit = 4'h8;
         3'h4: tone_bit = 4'h9;
         3'h5: tone_bit = 4'ha;
         3'h6: tone_bit = 4'hb;
         default: tone_bit = 4'hc;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_out_o <= 1'b0;
      end else begin
         // Low while disabled; a new select acts at once
         tone_out_o <= tone_ctrl_reg[`FRT_TONE_EN] & tone_div[tone_bit];
      end
   end
endmodule // frt_timer

/* testbench/frt_timer_properties.sv */
// Port checker for the free-running timer
`timescale 1ns/1ns
`include "frt_cfg.svh"
module frt_timer_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`FRT_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic match_irq_o,
   input wire logic toggle_out_o,
   input wire logic tone_out_o
);
   logic wr; // Lane 0 write landing now
   logic tone_en; // Last written tone enable
   logic out_en; // Last written toggle output enable
   logic mask; // Last written match mask
   assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   // Mirror the control bits as writes land
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_en <= 1'b0;
         out_en <= 1'b0;
         mask <= 1'b1;
      end else if (wr && wb_adr_i == `FRT_OFS_TONE) begin
         tone_en <= wb_dat_i[`FRT_TONE_EN];
      end else if (wr && wb_adr_i == `FRT_OFS_MODE) begin
         out_en <= wb_dat_i[`FRT_MODE_TOE];
         mask <= wb_dat_i[`FRT_MODE_MASK];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_timely: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property
      (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
      !wb_ack_o && !match_irq_o && !toggle_out_o && !tone_out_o)
      else $error("output active after reset");
   a_tone_off: assert property
      (!tone_en && !$past(tone_en) |-> !tone_out_o)
      else $error("tone active while disabled");
   a_toggle_off: assert property
      (!out_en && !$past(out_en) |-> !toggle_out_o)
      else $error("toggle active while disabled");
   a_mask_quiet: assert property
      (mask && $past(mask) |-> !match_irq_o)
      else $error("match request while masked");
   a_irq_drop: assert property
      ($fell(match_irq_o) |-> $past(wr) || $past(wr, 2))
      else $error("match request fell without write");
   c_irq: cover property ($rose(match_irq_o));
   c_tone: cover property ($rose(tone_out_o));
   c_write: cover property (wr);
   c_toggle: cover property ($rose(toggle_out_o));
endmodule // frt_timer_properties

bind frt_timer frt_timer_properties chk (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
   .match_irq_o, .toggle_out_o, .tone_out_o);

/* testbench/frt_pin_model.sv */
// Capture pin source and tone pin observer
`timescale 1ns/1ns
module frt_pin_model (
   input wire logic clk_i,
   input wire logic tone_i,
   output logic pin_o
);
   initial pin_o = 1'b0; // Pin idles low
   task automatic drive(input logic v);
      @(posedge clk_i);
      pin_o <= v;
   endtask
   // Clocks between two tone edges, capped at lim
   task automatic half(input int lim, output int n);
      logic last;
      for (int i = 0; i < 2; i++) begin
         last = tone_i;
         n = 0;
         while (tone_i === last && n < lim) begin
            @(posedge clk_i);
            n++;
         end
      end
   endtask
endmodule // frt_pin_model

/* testbench/frt_timer_bench.sv */
// Self-checking bench for the free-running timer
`timescale 1ns/1ns
`include "frt_cfg.svh"
module frt_timer_bench;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [`FRT_ADDR_W-1:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic capture_trigger_pin_i, match_irq_o, toggle_out_o, tone_out_o;
   logic [15:0] v0, cmp;
   int error_cnt = 0;
   int compares = 0;
   int cyc_n, k, n;
   int divs [8] = '{4, 5, 8, 9, 10, 11, 12, 13}; // Tone exponents
   frt_timer dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .capture_trigger_pin_i, .match_irq_o, .toggle_out_o, .tone_out_o);
   frt_pin_model pin (.clk_i, .tone_i(tone_out_o),
      .pin_o(capture_trigger_pin_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Clocks since reset release, time base of the count model
   always @(posedge clk_i) cyc_n <= rst_i ? 0 : cyc_n + 1;
   task automatic check(input string w, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h seen %h", w, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Count model: a tick each four clocks, phase known to two ticks
   task automatic chk_cnt(input string w, input logic [15:0] v, int t);
      int e;
      e = t / 4;
      check(w, {16'h0, v},
         (v + 2 >= e && v <= e + 2) === 1'b1 ? v : e);
   endtask
   // One classic cycle, held until ack is sampled, bounded wait
   task automatic bus(input logic w, input logic [3:0] a, s,
      input logic [31:0] d);
      int i;
      i = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      rd = wb_dat_o;
      check("ack", i < 50, 1'b1);
      if (i >= 50)
         tally_and_finish();
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = '0;
      wb_sel_i = '0;
      wb_dat_i = '0;
      k = $urandom(1649);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(0, `FRT_OFS_MODE, 4'hf, 0);
      check("mode", rd, {`FRT_MATCH_RST, 8'h00, `FRT_MODE_RST});
      bus(0, `FRT_OFS_TONE, 4'hf, 0);
      check("tone reg", rd, 0);
      bus(0, 4'h2, 4'hf, 0);
      check("hole", rd, 0);
      bus(0, `FRT_OFS_COUNT, 4'hf, 0);
      chk_cnt("start", rd[15:0], cyc_n - 2);
      $display("reset test done");
      // low byte, low byte again, then high, then the whole word
      for (int i = 0; i < 3; i++) begin
         bus(0, `FRT_OFS_COUNT, 4'h1, 0);
         v0 = rd[15:0];
         chk_cnt("live", v0, cyc_n - 2);
         repeat ($urandom_range(60, 20)) @(posedge clk_i);
         bus(0, `FRT_OFS_COUNT, 4'h1, 0);
         check("held lo", rd[7:0], v0[7:0]);
         bus(0, `FRT_OFS_COUNT, 4'h2, 0);
         check("held hi", rd[15:8], v0[15:8]);
         bus(0, `FRT_OFS_COUNT, 4'hf, 0);
         chk_cnt("free", rd[15:0], cyc_n - 2);
      end
      $display("buffer test done");
      for (int e = 0; e < 4; e++) begin
         bus(1, `FRT_OFS_MODE, 4'h1, {24'h0, 2'b01, e[1:0], 4'h0});
         bus(0, `FRT_OFS_CAPTURE, 4'hf, 0);
         for (int lv = 1; lv >= 0; lv--) begin
            v0 = rd[15:0];
            pin.drive(lv[0]);
            n = cyc_n;
            repeat ($urandom_range(30, 10)) @(posedge clk_i);
            bus(0, `FRT_OFS_CAPTURE, 4'hf, 0);
            if (e[1 - lv])
               chk_cnt("capture", rd[15:0], n + 3);
            else
               check("no capture", rd[15:0], v0);
         end
      end
      $display("capture test done");
      bus(0, `FRT_OFS_COUNT, 4'hf, 0);
      cmp = rd[15:0] + 16'(16 + $urandom_range(8, 0));
      bus(1, `FRT_OFS_MODE, 4'hf, {cmp, 8'h00, 8'h40});
      repeat (8) @(posedge clk_i);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h1);
      n = 0;
      while (match_irq_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      check("irq", match_irq_o, 1'b1);
      if (n >= 200)
         tally_and_finish();
      chk_cnt("match time", cmp, cyc_n - 2);
      bus(0, `FRT_OFS_MODE, 4'hf, 0);
      check("flag", rd[7:0], 8'h81);
      bus(0, `FRT_OFS_COUNT, 4'hf, 0);
      chk_cnt("runs on", rd[15:0], cyc_n - 2);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h1);
      repeat (3) @(posedge clk_i);
      check("irq clear", match_irq_o, 1'b0);
      $display("match test done");
      // Slow count clock, so the half window is 32 clocks
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h43);
      bus(0, `FRT_OFS_COUNT, 4'hf, 0);
      cmp = rd[15:0] + 16'h0003;
      // high byte, low byte, clear flag, wait, then enable
      bus(1, `FRT_OFS_MODE, 4'h8, {cmp[15:8], 24'h0});
      bus(1, `FRT_OFS_MODE, 4'h4, {8'h0, cmp[7:0], 16'h0});
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h43);
      repeat (40) @(posedge clk_i);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h0b);
      n = 0;
      while (match_irq_o !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check("toggle irq", match_irq_o, 1'b1);
      if (n >= 300)
         tally_and_finish();
      check("toggle match", toggle_out_o, 1'b1);
      // Re-enable inside the window inverts once more
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h03);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h0b);
      check("toggle window", toggle_out_o, 1'b0);
      repeat (40) @(posedge clk_i);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h03);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h0b);
      check("toggle late", toggle_out_o, 1'b0);
      bus(1, `FRT_OFS_MODE, 4'h1, 32'h40);
      $display("toggle test done");
      for (int c = 0; c < 8; c++) begin
         bus(1, `FRT_OFS_TONE, 4'h1, {28'h0, c[2:0], 1'b1});
         pin.half(20000, k);
         check("tone half", k, 2 << divs[c]);
         if (k >= 20000)
            tally_and_finish();
      end
      bus(1, `FRT_OFS_TONE, 4'h1, 0);
      $display("tone test done");
      tally_and_finish();
   end
endmodule // frt_timer_bench
